// [adc_host_consts.svh]
// Timing and width constants for the two-step converter host controller.
// Assumes a 100 MHz system clock.
`ifndef ADC_HOST_CONSTS_SVH
`define ADC_HOST_CONSTS_SVH
`define CLK_PERIOD_NS 10
`define SAMPLE_LOW_NS 250
`define SAMPLE_LOW_CYC ((`SAMPLE_LOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define MUX_SETUP_NS 75
`define MUX_SETUP_CYC ((`MUX_SETUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define MUX_HOLD_NS 40
`define MUX_HOLD_CYC ((`MUX_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ACCESS_NS 60
`define ACCESS_CYC ((`ACCESS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RECOVER_NS 50
`define RECOVER_CYC ((`RECOVER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define EOC_TIMEOUT_NS 2000
`define EOC_TIMEOUT_CYC (`EOC_TIMEOUT_NS / `CLK_PERIOD_NS)
`define RESULT_BITS 10
`define COUNT_BITS 8
`define COUNT_ZERO 8'h00
`define COUNT_ONE 8'h01
`endif

// [adc_host_pkg.sv]
// Types shared by the converter host controller.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package adc_host_pkg;
  typedef enum logic {
    mode_strobe,
    mode_read
  } conv_mode_t;
  typedef enum logic [2:0] {
    st_idle,
    st_setup,
    st_sample,
    st_wait_eoc,
    st_access,
    st_recover
  } host_state_t;
endpackage
`default_nettype wire

// [adc_host.sv]
// Host controller that sequences conversions of the two-step converter.
// Assumes the converter pins are wired directly; end of conversion is
// asynchronous and is synchronised here.
//
// Notes on behaviour
// R1: Sample strobe is held low at least 250 ns in strobe mode.
// R2: Converter latches coarse result on strobe rise and starts fine step.
// R3: End flag falls about 600 ns after strobe rises in strobe mode.
// R4: Chip select is held low whenever either strobe must take effect.
// R5: Converter samples only while chip select and sample strobe are low.
// R6: Converter drives data only while chip select and read are low.
// R7: End flag returns high on the rising edge of read.
// R8: Channel selects are held valid around the sample strobe fall.
// R9: Two select bits pick one of four inputs, high bit first.
// R10: One select bit picks one of two inputs.
// R11: In read mode both strobes are joined and driven low together.
// R12: In read mode an internal timer ends coarse step by itself.
// R13: In read mode end flag falls about 850 ns after strobes fall.
// R14: Result has ten bits formed in two steps, six then four.
// R15: Upper six bits come from estimator and first comparator step.
// R16: Complete result is latched as one word after the second step.
// R17: Data shows previous result until end flag falls.
// R18: Data pins float except while chip select and read are low.
`include "adc_host_consts.svh"
`default_nettype none
module adc_host #(
  parameter int unsigned TIMEOUT_CYC = `EOC_TIMEOUT_CYC
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic start_in,
  input wire adc_host_pkg::conv_mode_t mode_in,
  input wire logic [1:0] channel_in,
  input wire logic eoc_n_in,
  input wire logic [`RESULT_BITS-1:0] data_in,
  output logic chip_select_n_out,
  output logic sample_n_out,
  output logic read_n_out,
  output logic channel_select_low_out,
  output logic channel_select_high_out,
  output logic [`RESULT_BITS-1:0] result_out,
  output logic result_valid_out,
  output logic timeout_out,
  output logic busy_out
);
  import adc_host_pkg::*;

  logic eoc_meta;
  logic eoc_sync;
  host_state_t state;
  host_state_t next_state;
  conv_mode_t mode;
  conv_mode_t next_mode;
  logic [15:0] count;
  logic [15:0] next_count;
  logic [15:0] wait_count;
  logic [15:0] next_wait_count;
  logic [1:0] channel;
  logic [1:0] next_channel;
  logic cs_n, next_cs_n, s_n, next_s_n, rd_n, next_rd_n;
  logic [`RESULT_BITS-1:0] result, next_result;
  logic valid, next_valid, tmo, next_tmo;
  logic busy_q, next_busy;
  logic [`RESULT_BITS-1:0] data_meta, data_sync;

  // The end flag and the data bus are asynchronous pins; two flops each.
  // The data bus settles well before capture, so its lag costs nothing.
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      eoc_meta <= 1'b1;
      eoc_sync <= 1'b1;
      data_meta <= '0;
      data_sync <= '0;
    end else begin
      eoc_meta <= eoc_n_in;
      eoc_sync <= eoc_meta;
      data_meta <= data_in;
      data_sync <= data_meta;
    end
  end

  function automatic logic [15:0] cyc(input int unsigned n);
    cyc = 16'(n);
  endfunction

  always_comb begin
    next_state = state;
    next_mode = mode;
    next_count = count;
    next_wait_count = wait_count;
    next_channel = channel;
    next_cs_n = cs_n;
    next_s_n = s_n;
    next_rd_n = rd_n;
    next_result = result;
    next_valid = 1'b0;
    next_tmo = 1'b0;
    if (count != 16'h0000) begin
      next_count = count - 16'h0001;
    end
    unique case (state)
      st_idle: begin
        if (start_in) begin
          next_mode = mode_in;
          next_channel = channel_in; // R9 R10
          next_cs_n = 1'b0; // R4
          next_count = cyc(`MUX_SETUP_CYC); // R8
          next_state = st_setup;
        end
      end
      st_setup: begin
        if (count == 16'h0000) begin
          next_s_n = 1'b0; // R5
          if (mode == mode_read) begin
            next_rd_n = 1'b0; // R11
          end
          next_count = cyc(`SAMPLE_LOW_CYC); // R1
          next_state = st_sample;
        end
      end
      st_sample: begin
        if (mode == mode_read) begin
          // Strobes stay low; the converter times the conversion. R12
          next_wait_count = 16'h0000;
          next_state = st_wait_eoc;
        end else if (count == 16'h0000) begin
          next_s_n = 1'b1; // R2
          next_wait_count = 16'h0000;
          next_state = st_wait_eoc;
        end
      end
      st_wait_eoc: begin
        next_wait_count = wait_count + 16'h0001;
        if (!eoc_sync) begin // R3 R13 R17
          next_rd_n = 1'b0; // R6
          next_count = cyc(`ACCESS_CYC);
          next_state = st_access;
        end else if (wait_count >= cyc(TIMEOUT_CYC)) begin
          next_tmo = 1'b1;
          next_cs_n = 1'b1;
          next_s_n = 1'b1;
          next_rd_n = 1'b1;
          next_count = cyc(`RECOVER_CYC);
          next_state = st_recover;
        end
      end
      st_access: begin
        if (count == 16'h0000) begin
          next_result = data_sync; // R14 R15 R16
          next_valid = 1'b1;
          next_rd_n = 1'b1; // R7 R18
          next_s_n = 1'b1;
          next_cs_n = 1'b1;
          next_count = cyc(`RECOVER_CYC);
          next_state = st_recover;
        end
      end
      st_recover: begin
        // Channel selects are held here to cover the converter hold time.
        if (count == 16'h0000) begin
          next_state = st_idle;
        end
      end
      default: next_state = st_idle;
    endcase
    next_busy = (next_state != st_idle);
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state <= st_idle;
      mode <= mode_strobe;
      count <= 16'h0000;
      wait_count <= 16'h0000;
      channel <= 2'h0;
      cs_n <= 1'b1;
      s_n <= 1'b1;
      rd_n <= 1'b1;
      result <= '0;
      valid <= 1'b0;
      tmo <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      state <= next_state;
      mode <= next_mode;
      count <= next_count;
      wait_count <= next_wait_count;
      channel <= next_channel;
      cs_n <= next_cs_n;
      s_n <= next_s_n;
      rd_n <= next_rd_n;
      result <= next_result;
      valid <= next_valid;
      tmo <= next_tmo;
      busy_q <= next_busy;
    end
  end

  assign chip_select_n_out = cs_n;
  assign sample_n_out = s_n;
  assign read_n_out = rd_n;
  assign channel_select_low_out = channel[0];
  assign channel_select_high_out = channel[1];
  assign result_out = result;
  assign result_valid_out = valid;
  assign timeout_out = tmo;
  assign busy_out = busy_q;

  // Strobe low time in strobe mode is at least the sample time.
  logic [15:0] s_low_cnt;
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s_low_cnt <= 16'h0000;
    end else begin
      s_low_cnt <= s_n ? 16'h0000 : s_low_cnt + 16'h0001;
    end
  end

  a_sample_low_time: assert property ( // R1
    @(posedge clk_in) disable iff (!resetn_in)
    (mode == mode_strobe && $rose(s_n)) |->
      $past(s_low_cnt) >= cyc(`SAMPLE_LOW_CYC))
    else $error("sample strobe released too early");

  a_strobe_needs_cs: assert property ( // R4
    @(posedge clk_in) disable iff (!resetn_in)
    (!s_n || !rd_n) |-> !cs_n)
    else $error("strobe low without chip select");

  a_read_joined: assert property ( // R11
    @(posedge clk_in) disable iff (!resetn_in)
    (mode == mode_read && state inside {st_sample, st_wait_eoc}) |->
      (s_n == rd_n))
    else $error("joined strobes differ in read mode");

  a_channel_stable: assert property ( // R8
    @(posedge clk_in) disable iff (!resetn_in)
    (state != st_idle) |=> $stable(channel) || $past(state) == st_idle)
    else $error("channel select changed during conversion");

  a_read_waits_eoc: assert property ( // R17
    @(posedge clk_in) disable iff (!resetn_in)
    (mode == mode_strobe && $fell(rd_n)) |-> !$past(eoc_sync))
    else $error("read started before end of conversion");

  a_capture_after_rd: assert property ( // R6
    @(posedge clk_in) disable iff (!resetn_in)
    valid |-> !$past(rd_n) && !$past(cs_n))
    else $error("result captured without read window");

  a_rd_release: assert property ( // R7
    @(posedge clk_in) disable iff (!resetn_in)
    $rose(rd_n) |-> valid || tmo)
    else $error("read released without capture or timeout");

  a_setup_before_s: assert property ( // R8
    @(posedge clk_in) disable iff (!resetn_in)
    $fell(s_n) |-> $past(state, 2) == st_setup)
    else $error("sample strobe fell without setup time");

  c_strobe_conv: cover property (@(posedge clk_in) disable iff (!resetn_in)
    mode == mode_strobe && valid);
  c_read_conv: cover property (@(posedge clk_in) disable iff (!resetn_in)
    mode == mode_read && valid);
  c_timeout: cover property (@(posedge clk_in) disable iff (!resetn_in)
    tmo);
endmodule // adc_host
`default_nettype wire

// [adc_dev_model.sv]
// Behavioural model of the two-step converter as seen at its pins.
// Assumes the host drives chip select and strobes; delays are in ns.
`default_nettype none
module adc_dev_model (
  input wire logic cs_n_in,
  input wire logic s_n_in,
  input wire logic rd_n_in,
  input wire logic sel_low_in,
  input wire logic sel_high_in,
  input wire logic stall_in,
  input wire logic [31:0] extra_ns_in,
  output logic eoc_n_out,
  output logic [9:0] data_out,
  output logic viol_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] ch = 2'h0;
  logic [7:0] cnt = 8'h00;
  logic [9:0] word = 10'h000;
  logic joined = 1'b0;
  time t0 = 0;
  initial begin
    eoc_n_out = 1'b1;
    viol_out = 1'b0;
  end
  // A released bus shows the inverse word so a stale copy never matches.
  assign data_out = (!cs_n_in && !rd_n_in) ? word : ~word;
  task automatic convert(input int unsigned dly);
    #(dly + extra_ns_in);
    if ({sel_high_in, sel_low_in} !== ch) viol_out = 1'b1;
    if (!stall_in) begin
      word = {ch, cnt};
      cnt++;
      eoc_n_out = 1'b0;
    end
  endtask
  always @(negedge s_n_in) begin
    if (!cs_n_in) begin
      ch = {sel_high_in, sel_low_in};
      t0 = $time;
      #1;
      joined = !rd_n_in;
      if (joined) convert(849);
    end
  end
  always @(posedge s_n_in) begin
    if (!cs_n_in && !joined) begin
      if ($time - t0 < 250) viol_out = 1'b1;
      convert(600);
    end
  end
  always @(posedge rd_n_in) eoc_n_out = 1'b1;
  always @(negedge s_n_in or negedge rd_n_in) begin
    if (cs_n_in) viol_out = 1'b1;
  end
endmodule // adc_dev_model
`default_nettype wire

// [adc_host_tb.sv]
// Self-checking bench for the converter host controller.
// Assumes the converter model in adc_dev_model.sv on the far side.
`default_nettype none
module adc_host_tb import adc_host_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic start_in = 1'b0;
  conv_mode_t mode_in = mode_strobe;
  logic [1:0] channel_in = 2'h0;
  logic stall = 1'b0;
  logic [31:0] extra_ns = 32'h0;
  logic eoc_n, cs_n, s_n, rd_n, sel_lo, sel_hi, viol, valid, tmo, busy;
  logic [9:0] data, result;
  int error_cnt = 0;
  int comparisons = 0;
  // Each row holds mode, channel and the word the host should capture.
  logic [12:0] rows [8] = '{13'h0000, 13'h0501, 13'h0a02, 13'h0f03,
    13'h1f04, 13'h1a05, 13'h1506, 13'h1007};
  adc_host #(.TIMEOUT_CYC(150)) dut_u (.clk_in(clk_in),
    .resetn_in(resetn_in), .start_in(start_in), .mode_in(mode_in),
    .channel_in(channel_in), .eoc_n_in(eoc_n), .data_in(data),
    .chip_select_n_out(cs_n), .sample_n_out(s_n), .read_n_out(rd_n),
    .channel_select_low_out(sel_lo), .channel_select_high_out(sel_hi),
    .result_out(result), .result_valid_out(valid), .timeout_out(tmo),
    .busy_out(busy));
  adc_dev_model dev_u (.cs_n_in(cs_n), .s_n_in(s_n), .rd_n_in(rd_n),
    .sel_low_in(sel_lo), .sel_high_in(sel_hi), .stall_in(stall),
    .extra_ns_in(extra_ns), .eoc_n_out(eoc_n), .data_out(data),
    .viol_out(viol));
  initial begin
    forever #5 clk_in = ~clk_in;
  end
  task automatic finish_test;
    if (error_cnt == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [9:0] exp, got);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic run(input logic [12:0] r, input logic exp_tmo);
    int n;
    @(posedge clk_in);
    mode_in <= conv_mode_t'(r[12]);
    channel_in <= r[11:10];
    start_in <= 1'b1;
    @(posedge clk_in);
    start_in <= 1'b0;
    for (n = 0; n < 400; n++) begin
      @(posedge clk_in);
      #1;
      if (valid === 1'b1 || tmo === 1'b1) break;
    end
    if (n == 400) begin
      check("done", 10'h001, {9'h0, valid});
      finish_test();
    end
    check("selects", {8'h0, r[11:10]}, {8'h0, sel_hi, sel_lo});
    check("result", r[9:0], result);
    check("timeout", {9'h0, exp_tmo}, {9'h0, tmo});
    @(posedge clk_in);
    #1;
    check("pulses", 10'h000, {8'h0, valid, tmo});
    for (n = 0; n < 40 && busy !== 1'b0; n++) @(posedge clk_in);
    check("idle", 10'h0, {9'h0, busy});
    if (busy !== 1'b0) finish_test();
  endtask
  task automatic check_reset;
    check("reset pins", 10'h007, {7'h0, cs_n, s_n, rd_n});
    check("reset result", 10'h000, result);
    check("reset busy", 10'h000, {9'h0, busy});
  endtask
  initial begin
    repeat (5) @(posedge clk_in);
    check_reset();
    resetn_in <= 1'b1;
    for (int i = 0; i < 8; i++) run(rows[i], 1'b0);
    extra_ns <= 32'd600;
    run(13'h0508, 1'b0);
    stall <= 1'b1;
    extra_ns <= 32'd0;
    run(13'h0508, 1'b1);
    stall <= 1'b0;
    run(13'h1a09, 1'b0);
    check("host order", 10'h0, {9'h0, viol});
    @(posedge clk_in);
    start_in <= 1'b1;
    repeat (20) @(posedge clk_in);
    resetn_in <= 1'b0;
    start_in <= 1'b0;
    @(posedge clk_in);
    #1;
    check_reset();
    @(posedge clk_in);
    resetn_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    #1;
    check_reset();
    finish_test();
  end
endmodule // adc_host_tb
`default_nettype wire
